// ### adcsb_ctrl.sv
// converter control register, busy tracking, channel routing and interrupt
`timescale 1ns/1ps
`default_nettype none
module adcsb_ctrl (
    // clock and reset
    input  wire logic                               i_clk,
    input  wire logic                               i_reset,
    // register port
    input  wire logic [adcsb_pkg::ADDR_W-1:0]       i_addr,
    input  wire logic [adcsb_pkg::DATA_W-1:0]       i_wdata,
    input  wire logic                               i_wr,
    input  wire logic                               i_rd,
    output logic      [adcsb_pkg::DATA_W-1:0]       o_rdata,
    // conversion core
    input  wire logic                               i_conv_done,
    input  wire logic [adcsb_pkg::RES_W-1:0]        i_conv_result,
    output logic                                    o_conv_start,
    output logic                                    o_conv_enable,
    output logic      [adcsb_pkg::CHAN_N-1:0]       o_external_analog_inputs_sel,
    // interrupt
    output logic                                    o_irq
);
    ////////////////////////////////////////////////////////////////////////////
    // control fields
    logic                          start_r;
    logic                          converter_enable_r;
    logic                          result_alignment_select_r;
    logic [3:0]                    external_channel_select_r;
    adcsb_pkg::adcsb_state_t       state_r;
    logic [adcsb_pkg::IRQ_N-1:0]   irq_st_r;
    logic [adcsb_pkg::IRQ_N-1:0]   irq_msk_r;
    logic [7:0]                    result_high_byte;
    logic [7:0]                    result_low_byte;
    logic                          fire;

    ////////////////////////////////////////////////////////////////////////////
    // decode
    wire logic        wr_ctrl  = i_wr & (i_addr == adcsb_pkg::OFS_CTRL);
    wire logic        wr_ist   = i_wr & (i_addr == adcsb_pkg::OFS_IRQ_ST);
    wire logic        wr_msk   = i_wr & (i_addr == adcsb_pkg::OFS_IRQ_MSK);
    wire logic        conversion_busy_flag = (state_r != adcsb_pkg::ST_IDLE);
    wire logic        launch   = fire & converter_enable_r & ~conversion_busy_flag;
    wire logic        dropped  = fire & ~launch;
    wire logic        done_ev  = i_conv_done & (state_r == adcsb_pkg::ST_BUSY);
    wire logic        capture  = done_ev & converter_enable_r;
    wire logic [7:0]  ctrl_rd  = {start_r, conversion_busy_flag, converter_enable_r,
                                  result_alignment_select_r, external_channel_select_r};
    wire logic [adcsb_pkg::IRQ_N-1:0] irq_set = {dropped, done_ev};
    wire logic [adcsb_pkg::IRQ_N-1:0] irq_st_nxt =
        irq_set | (irq_st_r & ~(wr_ist ? i_wdata[adcsb_pkg::IRQ_N-1:0] : '0));
    wire logic [7:0]  rd_mux   =
        (i_addr == adcsb_pkg::OFS_CTRL)    ? ctrl_rd :
        (i_addr == adcsb_pkg::OFS_RES_HI)  ? result_high_byte :
        (i_addr == adcsb_pkg::OFS_RES_LO)  ? result_low_byte :
        (i_addr == adcsb_pkg::OFS_IRQ_ST)  ? {6'h00, irq_st_r} :
        (i_addr == adcsb_pkg::OFS_IRQ_MSK) ? {6'h00, irq_msk_r} : 8'h00;
    wire logic [adcsb_pkg::CHAN_N-1:0] route_nxt =
        adcsb_pkg::chan_route(external_channel_select_r);

    ////////////////////////////////////////////////////////////////////////////
    // state machine next value
    adcsb_pkg::adcsb_state_t state_nxt;
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            adcsb_pkg::ST_IDLE: begin
                if (launch) begin
                    state_nxt = adcsb_pkg::ST_LAUNCH;   // [R2]
                end
            end
            adcsb_pkg::ST_LAUNCH: begin
                state_nxt = adcsb_pkg::ST_BUSY;
            end
            adcsb_pkg::ST_BUSY: begin
                if (i_conv_done) begin
                    state_nxt = adcsb_pkg::ST_IDLE;     // [R3]
                end
            end
            default: begin
                state_nxt = adcsb_pkg::ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // control register, busy bit excluded from writes
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            start_r                   <= adcsb_pkg::RST_CTRL[7];    // [R10]
            converter_enable_r        <= adcsb_pkg::RST_CTRL[5];
            result_alignment_select_r <= adcsb_pkg::RST_CTRL[4];
            external_channel_select_r <= adcsb_pkg::RST_CTRL[3:0];
        end else if (wr_ctrl) begin
            start_r                   <= i_wdata[adcsb_pkg::BIT_START];   // [R1]
            converter_enable_r        <= i_wdata[adcsb_pkg::BIT_ENABLE];  // [R5]
            result_alignment_select_r <= i_wdata[adcsb_pkg::BIT_ALIGN];   // [R7]
            external_channel_select_r <= i_wdata[adcsb_pkg::CHAN_MSB:0];  // [R9]
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_r <= adcsb_pkg::ST_IDLE;    // [R10]
        end else begin
            state_r <= state_nxt;             // [R4]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs to the core and interrupt
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_conv_start                 <= 1'b0;
            o_conv_enable                <= 1'b0;
            o_external_analog_inputs_sel <= '0;
            irq_st_r                     <= adcsb_pkg::RST_IRQ;
            irq_msk_r                    <= adcsb_pkg::RST_IRQ;
            o_irq                        <= 1'b0;
        end else begin
            o_conv_start                 <= launch;             // [R1]
            o_conv_enable                <= converter_enable_r; // [R5]
            o_external_analog_inputs_sel <= route_nxt;          // [R9]
            irq_st_r                     <= irq_st_nxt;
            irq_msk_r                    <= wr_msk ? i_wdata[adcsb_pkg::IRQ_N-1:0] : irq_msk_r;
            o_irq                        <= |(irq_st_nxt & (wr_msk ? i_wdata[adcsb_pkg::IRQ_N-1:0] : irq_msk_r));
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= i_rd ? rd_mux : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // submodules
    adcsb_start_det u_start (
        .i_clk       (i_clk),
        .i_reset     (i_reset),
        .i_start_bit (start_r),
        .o_fire      (fire)
    );

    // [R6] capture only while enabled
    adcsb_result_fmt #(
        .RES_W (adcsb_pkg::RES_W)
    ) u_fmt (
        .i_clk     (i_clk),
        .i_reset   (i_reset),
        .i_capture (capture),
        .i_align   (result_alignment_select_r),
        .i_result  (i_conv_result),
        .o_high    (result_high_byte),
        .o_low     (result_low_byte)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence s_start_rise;
        !start_r ##1 start_r;
    endsequence
    sequence s_start_fall;
        start_r ##1 !start_r;
    endsequence

    AST_START_FIRE: assert property (s_start_fall |=> fire) // [R1]
        else $error("start fall did not fire");
    AST_START_LAUNCH: assert property ((fire && converter_enable_r && !conversion_busy_flag)
        |=> o_conv_start ##1 !o_conv_start) // [R1]
        else $error("launch pulse missing or too long");
    AST_NO_SPURIOUS: assert property (o_conv_start |-> $past(fire)) // [R1]
        else $error("start pulse without sequence");
    AST_BUSY_SET: assert property ((s_start_rise ##[0:8] s_start_fall ##1
        (converter_enable_r && !conversion_busy_flag))
        |=> conversion_busy_flag) // [R2]
        else $error("busy sequence check");
    AST_BUSY_AFTER: assert property (o_conv_start |-> conversion_busy_flag ##1 conversion_busy_flag) // [R2]
        else $error("busy not set after launch");
    AST_BUSY_CLEAR: assert property ((state_r == adcsb_pkg::ST_BUSY && i_conv_done)
        |=> !conversion_busy_flag) // [R3]
        else $error("busy not cleared on done");
    AST_BUSY_RO: assert property ((wr_ctrl && i_wdata[adcsb_pkg::BIT_BUSY] && !conversion_busy_flag && !fire)
        |=> !conversion_busy_flag) // [R4]
        else $error("busy flag took a write");
    AST_ENABLE: assert property (wr_ctrl |=> ##1 o_conv_enable == $past(i_wdata[adcsb_pkg::BIT_ENABLE], 2)) // [R5]
        else $error("enable output wrong");
    AST_HOLD: assert property (!converter_enable_r |=> $stable(result_high_byte) && $stable(result_low_byte)) // [R6]
        else $error("result changed while disabled");
    AST_ALIGN_LEFT: assert property ((capture && !result_alignment_select_r)
        |=> result_high_byte == $past(i_conv_result[11:4]) && result_low_byte[3:0] == 4'h0) // [R7]
        else $error("left alignment wrong");
    AST_ALIGN_RIGHT: assert property ((capture && result_alignment_select_r)
        |=> result_low_byte == $past(i_conv_result[7:0]) && result_high_byte[7:4] == 4'h0) // [R8]
        else $error("right alignment wrong");
    AST_CHAN_FLOAT: assert property ((external_channel_select_r > adcsb_pkg::CHAN_MAX)
        |=> o_external_analog_inputs_sel == '0) // [R9]
        else $error("invalid code routed an input");
    AST_RESET_ZERO: assert property (@(posedge i_clk) disable iff (1'b0) i_reset |=> ctrl_rd == 8'h00) // [R10]
        else $error("control not zero in reset");
    AST_RDATA_ONCE: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data outside its cycle");
endmodule
`default_nettype wire

// ### adcsb_pkg.sv
// constants and types for the converter start, busy and channel control block
// Notes on behaviour
// R1: start bit low-high-low launches one conversion
// R2: busy flag set once start sequence seen
// R3: busy flag cleared when conversion finishes
// R4: busy flag is read-only to software
// R5: enable bit powers converter on or off
// R6: result bytes held while converter disabled
// R7: alignment bit chooses high/low byte split
// R8: twelve-bit result split over two bytes
// R9: codes 0..8 route input n, others float
// R10: control register resets to all zeros
// R11: software enables, selects, starts, then awaits idle
`default_nettype none
package adcsb_pkg;
    localparam int unsigned ADDR_W      = 3;
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned RES_W       = 12;
    localparam int unsigned CHAN_N      = 9;
    // register offsets
    localparam logic [2:0]  OFS_CTRL    = 3'h0;
    localparam logic [2:0]  OFS_RES_HI  = 3'h1;
    localparam logic [2:0]  OFS_RES_LO  = 3'h2;
    localparam logic [2:0]  OFS_IRQ_ST  = 3'h3;
    localparam logic [2:0]  OFS_IRQ_MSK = 3'h4;
    // control field positions
    localparam int unsigned BIT_START   = 7;
    localparam int unsigned BIT_BUSY    = 6;
    localparam int unsigned BIT_ENABLE  = 5;
    localparam int unsigned BIT_ALIGN   = 4;
    localparam int unsigned CHAN_MSB    = 3;
    localparam logic [3:0]  CHAN_MAX    = 4'h8;
    // interrupt status positions
    localparam int unsigned IRQ_DONE    = 0;
    localparam int unsigned IRQ_DROP    = 1;
    localparam int unsigned IRQ_N       = 2;
    // reset values
    localparam logic [7:0]  RST_CTRL    = 8'h00;
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [1:0]  RST_IRQ     = 2'h0;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_LAUNCH = 3'b010,
        ST_BUSY   = 3'b100
    } adcsb_state_t;

    // input routing: one-hot for valid codes, none for the rest
    function automatic logic [CHAN_N-1:0] chan_route(input logic [3:0] code);
        logic [CHAN_N-1:0] r;
        r = '0;
        if (code <= CHAN_MAX) begin
            r[code] = 1'b1;
        end
        return r;
    endfunction
endpackage
`default_nettype wire

// ### adcsb_start_det.sv
// detector for the low-high-low sequence of the start bit
`timescale 1ns/1ps
`default_nettype none
module adcsb_start_det (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_reset,
    // start bit level
    input  wire logic i_start_bit,
    // one-cycle launch pulse
    output logic      o_fire
);
    logic armed_r;
    wire  logic armed_nxt;
    wire  logic fire_nxt;

    assign fire_nxt  = armed_r & ~i_start_bit;   // [R1]
    assign armed_nxt = i_start_bit;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            armed_r <= 1'b0;
            o_fire  <= 1'b0;
        end else begin
            armed_r <= armed_nxt;
            o_fire  <= fire_nxt;
        end
    end
endmodule
`default_nettype wire

// ### adcsb_result_fmt.sv
// result byte formatter and holding registers
`timescale 1ns/1ps
`default_nettype none
module adcsb_result_fmt #(
    parameter int unsigned RES_W = adcsb_pkg::RES_W
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    // capture control
    input  wire logic             i_capture,
    input  wire logic             i_align,
    input  wire logic [RES_W-1:0] i_result,
    // result bytes
    output logic      [7:0]       o_high,
    output logic      [7:0]       o_low
);
    wire logic [7:0] high_nxt;
    wire logic [7:0] low_nxt;

    // [R7] [R8]
    assign high_nxt = i_align ? {4'h0, i_result[11:8]} : i_result[11:4];
    assign low_nxt  = i_align ? i_result[7:0] : {i_result[3:0], 4'h0};

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_high <= adcsb_pkg::RST_BYTE;
            o_low  <= adcsb_pkg::RST_BYTE;
        end else if (i_capture) begin
            o_high <= high_nxt;
            o_low  <= low_nxt;
        end
    end
endmodule
`default_nettype wire

// ### adcsb_core_model.sv
// behavioural conversion core beyond the control block
`timescale 1ns/1ps
`default_nettype none
module adcsb_core_model #(
    parameter int unsigned DELAY = 12
) (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    // control from the block
    input  wire logic        i_start,
    input  wire logic        i_enable,
    input  wire logic [8:0]  i_sel,
    // conversion answer
    output logic             o_done,
    output logic [11:0]      o_result
);
    int          cnt;
    logic [11:0] res;

    // position of the routed input, zero when none
    function automatic logic [11:0] chan_index(input logic [8:0] s);
        logic [11:0] k;
        k = 12'h000;
        for (int j = 0; j < 9; j++) begin
            if (s[j]) begin
                k = 12'(j);
            end
        end
        return k;
    endfunction

    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            cnt <= 0;
            res <= 12'h000;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start === 1'b1 && i_enable === 1'b1) begin
                cnt <= DELAY;
                res <= 12'ha50 | chan_index(i_sel);
            end else if (cnt == 1) begin
                cnt <= 0;
                o_done <= 1'b1;
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end
        end
    end

    // result lines only meaningful beside done
    assign o_result = o_done ? res : ~res;
endmodule
`default_nettype wire

// ### adc_start_busy_channel_ctrl_bench.sv
// register-level testbench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_start_busy_channel_ctrl_bench;
    logic        i_clk   = 1'b0;
    logic        i_reset = 1'b1;
    logic [2:0]  i_addr  = 3'h0;
    logic [7:0]  i_wdata = 8'h00;
    logic        i_wr    = 1'b0;
    logic        i_rd    = 1'b0;
    logic [7:0]  o_rdata;
    logic        conv_done;
    logic [11:0] conv_result;
    logic        conv_start;
    logic        conv_enable;
    logic [8:0]  sel;
    logic        o_irq;
    int          mismatches = 0;
    int          n_compared = 0;
    int          starts     = 0;

    always #12.5 i_clk = ~i_clk;
    always @(posedge i_clk) if (conv_start === 1'b1) starts++;

    adcsb_ctrl i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_conv_done(conv_done), .i_conv_result(conv_result),
        .o_conv_start(conv_start), .o_conv_enable(conv_enable), .o_external_analog_inputs_sel(sel),
        .o_irq(o_irq));
    adcsb_core_model #(.DELAY(12)) i_core (.i_clk(i_clk), .i_reset(i_reset), .i_start(conv_start),
        .i_enable(conv_enable), .i_sel(sel), .o_done(conv_done), .o_result(conv_result));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    task automatic rdc(input string what, input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check(what, {8'h00, d}, {8'h00, exp});
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    // enable and channel already set, then pulse start, await idle
    task automatic conv(input logic [7:0] c, input logic [7:0] hi, input logic [7:0] lo);
        logic [7:0] d;
        int         n;
        int         s0;
        s0 = starts;
        wr(3'h0, c | 8'h80);
        wr(3'h0, c);
        cycles(3);
        check("launch count", 16'(starts - s0), 16'h0001);
        rdc("busy set", 3'h0, c | 8'h40);
        d = 8'h40;
        n = 0;
        while (d[6] === 1'b1 && n < 40) begin
            rd(3'h0, d);
            n++;
        end
        check("busy clear", {8'h00, d}, {8'h00, c});
        rdc("result high", 3'h1, hi);
        rdc("result low", 3'h2, lo);
    endtask

    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #(25 * 6000);
        mismatches++;
        print_verdict();
    end

    initial begin
        repeat (8) @(posedge i_clk);
        i_reset <= 1'b0;
        rdc("ctrl reset", 3'h0, 8'h00);
        rdc("high reset", 3'h1, 8'h00);
        for (int i = 0; i < 16; i++) begin
            wr(3'h0, 8'h20 | 8'(i));
            cycles(1);
            check("routing", {7'h00, sel}, (i <= 8) ? (16'h0001 << i) : 16'h0000);
            check("enable on", {15'h0000, conv_enable}, 16'h0001);
        end
        wr(3'h0, 8'h43);
        rdc("busy write ignored", 3'h0, 8'h03);
        wr(3'h0, 8'h23);
        conv(8'h23, 8'ha5, 8'h30);
        rdc("done status", 3'h3, 8'h01);
        check("irq masked", {15'h0000, o_irq}, 16'h0000);
        wr(3'h4, 8'h01);
        cycles(2);
        check("irq raised", {15'h0000, o_irq}, 16'h0001);
        wr(3'h3, 8'h01);
        cycles(2);
        check("irq cleared", {15'h0000, o_irq}, 16'h0000);
        wr(3'h0, 8'h38);
        conv(8'h38, 8'h0a, 8'h58);
        wr(3'h3, 8'h03);
        wr(3'h0, 8'h18);
        wr(3'h0, 8'h98);
        wr(3'h0, 8'h18);
        cycles(4);
        check("enable off", {15'h0000, conv_enable}, 16'h0000);
        rdc("held high", 3'h1, 8'h0a);
        rdc("held low", 3'h2, 8'h58);
        rdc("dropped start", 3'h3, 8'h02);
        wr(3'h0, 8'ha0);
        cycles(10);
        rdc("start held high", 3'h0, 8'ha0);
        conv(8'h20, 8'ha5, 8'h00);
        for (int i = 5; i < 8; i++) begin
            wr(3'(i), 8'hff);
            rdc("unmapped", 3'(i), 8'h00);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
